// ---- src/pbs_status_regs.sv ----
// Basic status and identifier registers read over station management
`timescale 1ns/1ps
`default_nettype none
module pbs_status_regs #(
  parameter logic [15:0] OUI_HIGH = pbs_pkg::OUI_HIGH_DFLT,
  parameter logic [5:0]  OUI_LOW  = pbs_pkg::OUI_LOW_DFLT,
  parameter logic [5:0]  MODEL    = pbs_pkg::MODEL_DFLT,
  parameter logic [3:0]  REVISION = pbs_pkg::REV_DFLT
) (
  input  wire logic                         clock_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         mgmt_rd_in,
  input  wire logic                         mgmt_wr_in,
  input  wire logic [pbs_pkg::INDEX_W-1:0]  mgmt_index_in,
  input  wire logic [pbs_pkg::DATA_W-1:0]   mgmt_wdata_in,
  input  wire logic                         an_complete_in,
  input  wire logic                         link_up_in,
  input  wire logic                         remote_fault_in,
  input  wire logic                         jabber_in,
  output logic      [pbs_pkg::DATA_W-1:0]   mgmt_rdata_out,
  output logic                              mgmt_rvalid_out
);
  pbs_latch_if lif ();

  logic [pbs_pkg::DATA_W-1:0] mgmt_rdata_r;
  logic [pbs_pkg::DATA_W-1:0] mgmt_rdata_nxt;
  logic                       mgmt_rvalid_r;
  logic                       an_done_r;
  logic                       hit_status;
  logic                       hit_id_high;
  logic                       hit_id_low;
  logic [pbs_pkg::DATA_W-1:0] status_word;
  logic [pbs_pkg::DATA_W-1:0] id_high_word;
  logic [pbs_pkg::DATA_W-1:0] id_low_word;
  logic                       wr_seen;

  // Writes are accepted on the bus but nothing here is writable
  assign wr_seen = mgmt_wr_in & ~mgmt_rd_in;

  // Index decode
  assign hit_status  = (mgmt_index_in == pbs_pkg::IDX_STATUS);
  assign hit_id_high = (mgmt_index_in == pbs_pkg::IDX_ID_HIGH);
  assign hit_id_low  = (mgmt_index_in == pbs_pkg::IDX_ID_LOW);

  // Latching cells are fed live conditions and released by a status read
  assign lif.rfault_evt = remote_fault_in;
  assign lif.jabber_evt = jabber_in;
  assign lif.link_up    = link_up_in;
  assign lif.rd_clr     = mgmt_rd_in & hit_status;

  pbs_latch_cells u_cells (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .lif      (lif)
  );

  // Status word: fixed capabilities with four live bits merged in
  always_comb begin
    status_word = pbs_pkg::STATUS_FIXED;
    status_word[pbs_pkg::BIT_AN_DONE] = an_done_r;
    status_word[pbs_pkg::BIT_RFAULT]  = lif.rfault_view;
    status_word[pbs_pkg::BIT_LINK]    = lif.link_view;
    status_word[pbs_pkg::BIT_JABBER]  = lif.jabber_view;
  end

  // Identifier words are constants, so writes cannot reach them
  assign id_high_word = OUI_HIGH;
  assign id_low_word  = {OUI_LOW, MODEL, REVISION};

  // Read mux; unmapped indices answer zero
  assign mgmt_rdata_nxt = !mgmt_rd_in ? mgmt_rdata_r :
                          hit_status  ? status_word  :
                          hit_id_high ? id_high_word :
                          hit_id_low  ? id_low_word  : pbs_pkg::DATA_ZERO;

  // Completion flag is registered so the read sees a stable reset value
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      an_done_r <= 1'b0;
    end else begin
      an_done_r <= an_complete_in;
    end
  end

  // Read data held until the next read; valid is the read strobe delayed one cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt_rdata_r  <= pbs_pkg::DATA_ZERO;
      mgmt_rvalid_r <= 1'b0;
    end else begin
      mgmt_rdata_r  <= mgmt_rdata_nxt;
      mgmt_rvalid_r <= mgmt_rd_in;
    end
  end

  assign mgmt_rdata_out  = mgmt_rdata_r;
  assign mgmt_rvalid_out = mgmt_rvalid_r;

  sequence s_status_read;
    mgmt_rd_in && hit_status;
  endsequence

  sequence s_jabber_then_read;
    jabber_in ##1 (!mgmt_rd_in [*1]) ##1 s_status_read;
  endsequence

  chk_fixed_caps: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_status_read |=> (mgmt_rdata_out & 16'hffc9) == pbs_pkg::STATUS_FIXED)
    else $error("status capability bits wrong");
  chk_no_t4_t2: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_status_read |=> !mgmt_rdata_out[15] && !mgmt_rdata_out[10] && !mgmt_rdata_out[9]
      && !mgmt_rdata_out[7])
    else $error("unsupported ability reported");
  chk_ext_preamble: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_status_read |=> mgmt_rdata_out[8] && mgmt_rdata_out[6] && mgmt_rdata_out[3]
      && mgmt_rdata_out[0])
    else $error("supported ability missing");
  chk_an_done_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_status_read |=> mgmt_rdata_out[pbs_pkg::BIT_AN_DONE] == $past(an_done_r))
    else $error("auto-negotiation complete bit wrong");
  chk_jabber_reported: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_jabber_then_read |=> mgmt_rdata_out[pbs_pkg::BIT_JABBER])
    else $error("jabber not reported on next status read");
  chk_link_needs_up: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (s_status_read and !link_up_in) |=> !mgmt_rdata_out[pbs_pkg::BIT_LINK])
    else $error("link reported up while down");
  chk_id_high_word: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    mgmt_rd_in && hit_id_high |=> mgmt_rdata_out == OUI_HIGH)
    else $error("identifier high word wrong");
  chk_id_low_word: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    mgmt_rd_in && hit_id_low |=> mgmt_rdata_out == {OUI_LOW, MODEL, REVISION})
    else $error("identifier low word wrong");
  chk_write_no_effect: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_seen |=> $stable(mgmt_rdata_out) && !mgmt_rvalid_out)
    else $error("write changed read data");
  chk_read_valid: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    mgmt_rd_in |=> mgmt_rvalid_out ##1 (mgmt_rvalid_out == $past(mgmt_rd_in)))
    else $error("read valid timing wrong");
endmodule : pbs_status_regs
`default_nettype wire

// ---- src/pbs_pkg.sv ----
// Constants for the basic status and identifier register bank
// Overview of operation
// - Index 1 returns a 16-bit read-only status word of capabilities and live condition.
// - Status bit 15 always reads 0, meaning no 100BASE-T4 ability.
// - Status bits 14 to 11 read 1 for 100BASE-X FD, 100BASE-X HD, 10BASE-T FD, 10BASE-T HD.
// - Status bits 10 and 9 read 0, meaning no 100BASE-T2 full or half duplex ability.
// - Status bit 8 reads 1, meaning extended status is held at index 15.
// - Status bit 7 reads 0, meaning transmit only once a valid link exists.
// - Status bit 6 reads 1 and frames without preamble are accepted.
// - Status bit 5 resets to 0 and reads 1 only once auto-negotiation is complete.
// - Status bit 4 latches high on a remote fault and holds until read, reset value 0.
// - Status bit 3 reads 1, meaning auto-negotiation ability.
// - Status bit 2 shows link up, latches low on a link drop until read, reset value 0.
// - Status bit 1 latches high on jabber and holds until read, reset value 0.
// - Status bit 0 reads 1, meaning the extended register set exists.
// - Index 2 returns OUI bits 3 to 18 in bits 15:0, in order.
// - Index 3 returns OUI bits 19 to 24 in 15:10, model in 9:4 and revision in 3:0.
package pbs_pkg;
  localparam int          INDEX_W        = 5;
  localparam int          DATA_W         = 16;
  localparam logic [4:0]  IDX_STATUS     = 5'h01;
  localparam logic [4:0]  IDX_ID_HIGH    = 5'h02;
  localparam logic [4:0]  IDX_ID_LOW     = 5'h03;
  // Fixed capability pattern, live bits held at zero here
  localparam logic [15:0] STATUS_FIXED   = 16'h7949;
  localparam int          BIT_AN_DONE    = 5;
  localparam int          BIT_RFAULT     = 4;
  localparam int          BIT_LINK       = 2;
  localparam int          BIT_JABBER     = 1;
  localparam logic [15:0] DATA_ZERO      = 16'h0000;
  // Identity defaults are arbitrary neutral values
  localparam logic [15:0] OUI_HIGH_DFLT  = 16'h0a5a;
  localparam logic [5:0]  OUI_LOW_DFLT   = 6'h15;
  localparam logic [5:0]  MODEL_DFLT     = 6'h2a;
  localparam logic [3:0]  REV_DFLT       = 4'h1;
endpackage : pbs_pkg

// ---- src/pbs_latch_if.sv ----
// Interface between the register front end and the latching status cells
`timescale 1ns/1ps
`default_nettype none
interface pbs_latch_if;
  logic rfault_evt;
  logic jabber_evt;
  logic link_up;
  logic rd_clr;
  logic rfault_view;
  logic jabber_view;
  logic link_view;
  modport cells (input rfault_evt, jabber_evt, link_up, rd_clr,
                 output rfault_view, jabber_view, link_view);
  modport front (output rfault_evt, jabber_evt, link_up, rd_clr,
                 input rfault_view, jabber_view, link_view);
endinterface : pbs_latch_if
`default_nettype wire

// ---- src/pbs_latch_cells.sv ----
// Latching high and latching low status cells released by a status read
`timescale 1ns/1ps
`default_nettype none
module pbs_latch_cells (
  input  wire logic    clock_in,
  input  wire logic    rst_n_in,
  pbs_latch_if.cells   lif
);
  logic rfault_r;
  logic jabber_r;
  logic link_fail_r;

  // Set wins over the read release so an event in the read cycle survives
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rfault_r    <= 1'b0;
      jabber_r    <= 1'b0;
      link_fail_r <= 1'b1;   // Link reads down until first read after reset
    end else begin
      rfault_r    <= lif.rfault_evt | (rfault_r & ~lif.rd_clr);
      jabber_r    <= lif.jabber_evt | (jabber_r & ~lif.rd_clr);
      link_fail_r <= ~lif.link_up | (link_fail_r & ~lif.rd_clr);
    end
  end

  // Views include the live level so a read never misses the current state
  assign lif.rfault_view = rfault_r | lif.rfault_evt;
  assign lif.jabber_view = jabber_r | lif.jabber_evt;
  assign lif.link_view   = lif.link_up & ~link_fail_r;

  chk_rfault_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lif.rfault_evt ##1 !lif.rd_clr [*2] |-> lif.rfault_view)
    else $error("remote fault latch dropped before read");
  chk_jabber_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lif.jabber_evt ##1 !lif.rd_clr [*2] |-> lif.jabber_view)
    else $error("jabber latch dropped before read");
  chk_link_low_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !lif.link_up ##1 !lif.rd_clr |-> !lif.link_view)
    else $error("link latch rose without a read");
  chk_release_after_read: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lif.rd_clr && lif.link_up && !lif.jabber_evt ##1 lif.link_up && !lif.jabber_evt
      |-> lif.link_view
      && !lif.jabber_view)
    else $error("latched bits not released by read");
endmodule : pbs_latch_cells
`default_nettype wire

// ---- bench/pbs_mgmt_model.sv ----
// Station management controller model issuing single register accesses
`timescale 1ns/1ps
`default_nettype none
module pbs_mgmt_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic             rd_out,
  output logic             wr_out,
  output logic [4:0]       index_out,
  output logic [15:0]      wdata_out
);
  // Idle bus at time zero
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    index_out = 5'h1f;
    wdata_out = 16'h0000;
  end

  // One request cycle; index and data inverted after, so a stale value never looks held
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd_data, output logic vld);
    @(posedge clock_in);
    rd_out <= ~wr;
    wr_out <= wr;
    index_out <= idx;
    wdata_out <= wd;
    @(posedge clock_in);
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    index_out <= ~idx;
    wdata_out <= ~wd;
    #1;
    rd_data = rdata_in;
    vld = rvalid_in;
  endtask : access
endmodule : pbs_mgmt_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the status and identifier registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] S = pbs_pkg::STATUS_FIXED;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        an = 1'b0;
  logic        link = 1'b0;
  logic        rf = 1'b0;
  logic        jab = 1'b0;
  logic        rd, wr, rvalid, vld;
  logic [4:0]  idx;
  logic [15:0] wd, rdata, got;
  int          n_fail = 0;
  int          total_checks = 0;

  always #10 clock_in = ~clock_in;

  pbs_status_regs i_pbs_status_regs (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .mgmt_rd_in(rd), .mgmt_wr_in(wr), .mgmt_index_in(idx), .mgmt_wdata_in(wd),
    .an_complete_in(an), .link_up_in(link), .remote_fault_in(rf), .jabber_in(jab),
    .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid));

  pbs_mgmt_model i_pbs_mgmt_model (.clock_in(clock_in), .rdata_in(rdata),
    .rvalid_in(rvalid), .rd_out(rd), .wr_out(wr), .index_out(idx), .wdata_out(wd));

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Read answers exactly one cycle after the request
  task automatic rd_chk(input logic [4:0] i, input logic [15:0] exp);
    i_pbs_mgmt_model.access(1'b0, i, 16'h0000, got, vld);
    check("rvalid", 16'h0001, {15'h0000, vld});
    check("rdata", exp, got);
  endtask : rd_chk

  // Writes are dropped without an answer
  task automatic wr_chk(input logic [4:0] i, input logic [15:0] d);
    i_pbs_mgmt_model.access(1'b1, i, d, got, vld);
    check("write rvalid", 16'h0000, {15'h0000, vld});
  endtask : wr_chk

  // Line conditions change one cycle at a time
  task automatic line(input logic a, input logic l, input logic r, input logic j);
    @(posedge clock_in);
    an <= a;
    link <= l;
    rf <= r;
    jab <= j;
  endtask : line

  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd_chk(5'h01, S);
    rd_chk(5'h02, pbs_pkg::OUI_HIGH_DFLT);
    rd_chk(5'h03, {pbs_pkg::OUI_LOW_DFLT, pbs_pkg::MODEL_DFLT, pbs_pkg::REV_DFLT});
    rd_chk(5'h00, 16'h0000);
    line(1'b1, 1'b1, 1'b0, 1'b0);
    rd_chk(5'h01, S | 16'h0020);
    rd_chk(5'h01, S | 16'h0024);
    line(1'b1, 1'b0, 1'b0, 1'b0);
    line(1'b1, 1'b1, 1'b1, 1'b0);
    line(1'b1, 1'b1, 1'b0, 1'b0);
    // Identifier read in between must not release the latches
    rd_chk(5'h02, pbs_pkg::OUI_HIGH_DFLT);
    rd_chk(5'h01, S | 16'h0030);
    rd_chk(5'h01, S | 16'h0024);
    line(1'b1, 1'b1, 1'b0, 1'b1);
    line(1'b1, 1'b1, 1'b0, 1'b0);
    rd_chk(5'h02, pbs_pkg::OUI_HIGH_DFLT);
    rd_chk(5'h01, S | 16'h0026);
    rd_chk(5'h01, S | 16'h0024);
    wr_chk(5'h01, 16'hffff);
    wr_chk(5'h02, 16'h0000);
    rd_chk(5'h01, S | 16'h0024);
    rd_chk(5'h02, pbs_pkg::OUI_HIGH_DFLT);
    // Jabber pulse read back straight away by a status read
    line(1'b1, 1'b1, 1'b0, 1'b1);
    line(1'b1, 1'b1, 1'b0, 1'b0);
    rd_chk(5'h01, S | 16'h0026);
    line(1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk(5'h01, S | 16'h0004);
    // Mid-run reset: link latch must read down once even with link up
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd_chk(5'h01, S);
    rd_chk(5'h01, S | 16'h0004);
    summarize();
  end

  // Watchdog far beyond the roughly 60 cycles the tests need
  initial begin
    repeat (1000) @(posedge clock_in);
    n_fail++;
    summarize();
  end
endmodule : tb
`default_nettype wire
